/* src/rotation_alarm.v */
// Purpose: phase rotation mismatch alarm with horn, lamp and acknowledge
// Assumes: AHB-Lite single word transfers, one 200 MHz clock
// Notes:   rotation indications arrive from pins and are synchronised
//
// Local design decisions: the address map and register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "rotation_alarm_defines.vh"
module rotation_alarm #(
    parameter integer TICK_DIV = `TICK_CYCLES
) (
    input  wire        CLK_SYS,
    input  wire        RST,
    input  wire        HSEL,
    input  wire [31:0] HADDR,
    input  wire [1:0]  HTRANS,
    input  wire        HWRITE,
    input  wire [2:0]  HSIZE,
    input  wire [31:0] HWDATA,
    input  wire        HREADY,
    output wire [31:0] HRDATA,
    output wire        HREADYOUT,
    output wire        HRESP,
    input  wire [1:0]  MODE_A,
    input  wire [1:0]  MODE_B,
    input  wire        ROT_A,
    input  wire        ROT_B,
    input  wire        VOLT_OK_A,
    input  wire        VOLT_OK_B,
    input  wire        DISCRETE_INPUT_ONE,
    input  wire        DISCRETE_INPUT_TWO,
    input  wire        BUTTON_ACK,
    input  wire        DEAD_BUS_CLOSE_REQ,
    input  wire        SYNC_CLOSE_REQ,
    output reg         SYNC_CLOSE_EN,
    output reg         DEAD_BUS_CLOSE_EN,
    output reg         MISMATCH_FLAG,
    output reg         ROTATION_MISMATCH_MESSAGE,
    output reg  [2:0]  ALARM_CLASS,
    output reg         HORN_FLAG,
    output reg         LAMP_ON,
    output reg         LAMP_FLASH,
    output wire        IRQ
);
    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    localparam integer NS = 11;
    wire [NS-1:0] raw = {MODE_A, MODE_B, ROT_A, ROT_B, VOLT_OK_A, VOLT_OK_B,
                         DISCRETE_INPUT_ONE, DISCRETE_INPUT_TWO, BUTTON_ACK};
    reg  [NS-1:0] sync1_q;
    reg  [NS-1:0] sync2_q;
    reg           dead_req_q;
    reg           sync_req_q;

    always @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            sync1_q    <= {NS{1'b0}};
            sync2_q    <= {NS{1'b0}};
            dead_req_q <= 1'b0;
            sync_req_q <= 1'b0;
        end else begin
            sync1_q    <= raw;
            sync2_q    <= sync1_q;
            dead_req_q <= DEAD_BUS_CLOSE_REQ;
            sync_req_q <= SYNC_CLOSE_REQ;
        end
    end

    wire [1:0] mode_a  = sync2_q[10:9];
    wire [1:0] mode_b  = sync2_q[8:7];
    wire       rot_a   = sync2_q[6];
    wire       rot_b   = sync2_q[5];
    wire       vok_a   = sync2_q[4];
    wire       vok_b   = sync2_q[3];
    wire       lock_in = sync2_q[2];
    wire       ext_ack = sync2_q[1];
    wire       btn_in  = sync2_q[0];

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    reg  [31:0] ctrl_q;
    reg  [2:0]  mask_q;
    reg  [2:0]  irq_q;
    reg  [31:0] horn_delay_q;
    reg  [31:0] ack_delay_q;
    reg         alarm_q;
    reg         horn_q;
    reg         flash_q;
    reg  [31:0] horn_cnt_q;
    reg         ack_stage_q;
    reg         btn_q;

    wire        mon_en    = ctrl_q[`CTRL_MON_EN];
    wire        self_ack  = ctrl_q[`CTRL_SELF_ACK];
    wire        lockable  = ctrl_q[`CTRL_LOCKABLE];
    wire        rot_1ph   = ctrl_q[`CTRL_ROT_1PH];
    wire [2:0]  cls       = ctrl_q[`CTRL_CLASS_MSB:`CTRL_CLASS_LSB];

    // ----------------------------------------------------------------
    // ahb slave
    // ----------------------------------------------------------------
    reg         dp_wr_q;
    reg         dp_rd_q;
    reg  [7:0]  dp_addr_q;
    reg  [31:0] rdata_q;
    wire        ap_valid = HSEL & HREADY & HTRANS[1];

    assign HREADYOUT = 1'b1;
    assign HRESP     = 1'b0;
    assign HRDATA    = rdata_q;

    always @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            dp_wr_q   <= 1'b0;
            dp_rd_q   <= 1'b0;
            dp_addr_q <= 8'h00;
        end else begin
            dp_wr_q   <= ap_valid & HWRITE;
            dp_rd_q   <= ap_valid & ~HWRITE;
            dp_addr_q <= HADDR[7:0];
        end
    end

    wire irq_rd = ap_valid & ~HWRITE & (HADDR[7:0] == `REG_IRQ_STATUS);

    function [31:0] read_mux;
        input [7:0] a;
        begin
            case (a)
                `REG_CTRL:       read_mux = ctrl_q;
                `REG_STATUS:     read_mux = {26'h0, ack_stage_q, flash_q, horn_q, alarm_q, 2'h0};
                `REG_MASK:       read_mux = {29'h0, mask_q};
                `REG_HORN_DELAY: read_mux = horn_delay_q;
                `REG_ACK_DELAY:  read_mux = ack_delay_q;
                `REG_IRQ_STATUS: read_mux = {29'h0, irq_q};
                default:         read_mux = 32'h0000_0000;
            endcase
        end
    endfunction

    // read data captured at address phase, stands in the data phase
    always @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            rdata_q <= 32'h0000_0000;
        end else if (ap_valid & ~HWRITE) begin
            rdata_q <= read_mux(HADDR[7:0]);
        end
    end

    wire btn_sw = dp_wr_q & (dp_addr_q == `REG_CTRL) & HWDATA[`CTRL_BTN_ACK];

    always @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            ctrl_q       <= `CTRL_RESET;
            mask_q       <= 3'h0;
            horn_delay_q <= `HORN_DELAY_RESET;
            ack_delay_q  <= `ACK_DELAY_RESET;
        end else if (dp_wr_q) begin
            case (dp_addr_q)
                `REG_CTRL:       ctrl_q       <= {24'h0, 1'b0, HWDATA[6:0]};
                `REG_MASK:       mask_q       <= HWDATA[2:0];
                `REG_HORN_DELAY: horn_delay_q <= HWDATA;
                `REG_ACK_DELAY:  ack_delay_q  <= HWDATA;
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // time base and external acknowledge
    // ----------------------------------------------------------------
    wire tick;
    wire ext_pulse;

    tick_divider #(
        .DIV (TICK_DIV)
    ) u_tick (
        .clk  (CLK_SYS),
        .rst  (RST),
        .tick (tick)
    );

    ack_qualifier #(
        .W (16)
    ) u_ack (
        .clk       (CLK_SYS),
        .rst       (RST),
        .tick      (tick),
        .level     (ext_ack),
        .on_delay  (ack_delay_q[15:0]),
        .off_delay (ack_delay_q[31:16]),
        .pulse     (ext_pulse)
    );

    // ----------------------------------------------------------------
    // rotation check
    // ----------------------------------------------------------------
    function is_3ph;
        input [1:0] m;
        begin
            is_3ph = (m == `MODE_3PH_NEUTRAL) | (m == `MODE_3PH_NO_NEUT);
        end
    endfunction

    wire both_3ph = is_3ph(mode_a) & is_3ph(mode_b);
    wire both_1ph = (mode_a == `MODE_SINGLE_PHASE_TWO_WIRE) & (mode_b == `MODE_SINGLE_PHASE_TWO_WIRE);
    wire active_3 = both_3ph & vok_a & vok_b;
    // single-phase systems both take the configured sense, so never differ
    wire rot_a_eff = both_1ph ? rot_1ph : rot_a;
    wire rot_b_eff = both_1ph ? rot_1ph : rot_b;
    wire locked    = lockable & lock_in;
    wire fault     = mon_en & ~locked & active_3 & (rot_a_eff != rot_b_eff);

    // ----------------------------------------------------------------
    // alarm, horn and lamp
    // ----------------------------------------------------------------
    wire btn_rise  = btn_in & ~btn_q;
    wire manual    = btn_rise | btn_sw;
    wire ack_clear = manual | (ext_pulse & ack_stage_q);
    wire ack_horn  = manual | (ext_pulse & ~ack_stage_q);
    wire new_alarm = fault & ~alarm_q;
    wire hornable  = (cls >= `CLASS_B) & (cls <= `CLASS_F);
    wire horn_exp  = horn_q & (horn_delay_q != 32'h0) & tick &
                     (horn_cnt_q + 32'h1 >= horn_delay_q);

    always @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            alarm_q     <= 1'b0;
            horn_q      <= 1'b0;
            flash_q     <= 1'b0;
            horn_cnt_q  <= 32'h0000_0000;
            ack_stage_q <= 1'b0;
            btn_q       <= 1'b0;
        end else begin
            btn_q <= btn_in;
            if (fault) begin
                alarm_q <= 1'b1;
            end else if (self_ack | ack_clear) begin
                alarm_q <= 1'b0;
            end
            if (new_alarm & hornable) begin
                horn_q     <= 1'b1;
                flash_q    <= 1'b1;
                horn_cnt_q <= 32'h0000_0000;
            end else begin
                if (ack_horn | horn_exp) begin
                    horn_q <= 1'b0;
                end else if (horn_q & tick & (horn_delay_q != 32'h0)) begin
                    horn_cnt_q <= horn_cnt_q + 32'h1;
                end
                if (horn_exp | ack_clear) begin
                    flash_q <= 1'b0;
                end
            end
            if (new_alarm) begin
                ack_stage_q <= 1'b0;
            end else if (ext_pulse) begin
                ack_stage_q <= ~ack_stage_q;
            end
        end
    end

    // ----------------------------------------------------------------
    // interrupt status, cleared on read, set wins
    // ----------------------------------------------------------------
    wire [2:0] irq_ev = {ext_pulse, new_alarm & hornable, new_alarm};

    always @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            irq_q <= 3'h0;
        end else begin
            irq_q <= irq_ev | (irq_rd ? 3'h0 : irq_q);
        end
    end

    assign IRQ = |(irq_q & mask_q);

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    always @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            SYNC_CLOSE_EN             <= 1'b0;
            DEAD_BUS_CLOSE_EN         <= 1'b0;
            MISMATCH_FLAG             <= 1'b0;
            ROTATION_MISMATCH_MESSAGE <= 1'b0;
            ALARM_CLASS               <= `CLASS_A;
            HORN_FLAG                 <= 1'b0;
            LAMP_ON                   <= 1'b0;
            LAMP_FLASH                <= 1'b0;
        end else begin
            SYNC_CLOSE_EN             <= sync_req_q & ~alarm_q;
            DEAD_BUS_CLOSE_EN         <= dead_req_q;
            MISMATCH_FLAG             <= alarm_q;
            ROTATION_MISMATCH_MESSAGE <= alarm_q;
            ALARM_CLASS               <= cls;
            HORN_FLAG                 <= horn_q;
            LAMP_ON                   <= alarm_q & hornable;
            LAMP_FLASH                <= flash_q;
        end
    end
endmodule
`default_nettype wire

/* src/rotation_alarm_defines.vh */
// Purpose: constants for the phase rotation alarm and acknowledge block
// Assumes: 200 MHz system clock, 1 ms time-base tick
// Notes:   offsets, fields, reset values and timing counts
// Summary of operation
// - differing rotation senses raise the alarm and block synchronized closing.
// - the alarm never blocks dead busbar closing.
// - a trip sets the mismatch flag and the mismatch message.
// - checking needs both systems three-phase and voltage above half rated.
// - both single-phase two-wire use the configured rotation value.
// - a monitoring enable, on by default, gates checking.
// - the alarm has a class among A to F or Control.
// - with self-acknowledge on, the alarm clears once the fault is gone.
// - with self-acknowledge off, the alarm latches until acknowledged.
// - a lockable monitor evaluates only while lock status is false.
// - a new class B to F alarm flashes the lamp and sets the horn.
// - horn delay expiry makes the lamp steady and drops the horn.
// - a zero horn delay keeps the horn on until acknowledged.
// - external acknowledge first silences the horn, then clears inactive alarms.
// - external acknowledge needs the on-delay true and the off-delay false.
// - the lock condition suspends lockable monitors.
`ifndef ROTATION_ALARM_DEFINES_VH
`define ROTATION_ALARM_DEFINES_VH

// ----------------------------------------------------------------
// ahb register offsets
// ----------------------------------------------------------------
`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define REG_MASK        8'h08
`define REG_HORN_DELAY  8'h0C
`define REG_ACK_DELAY   8'h10
`define REG_IRQ_STATUS  8'h14

// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define CTRL_MON_EN     0
`define CTRL_SELF_ACK   1
`define CTRL_LOCKABLE   2
`define CTRL_ROT_1PH    3
`define CTRL_CLASS_LSB  4
`define CTRL_CLASS_MSB  6
`define CTRL_BTN_ACK    7
`define CTRL_RESET      32'h0000_0013

// ----------------------------------------------------------------
// alarm classes
// ----------------------------------------------------------------
`define CLASS_A         3'h0
`define CLASS_B         3'h1
`define CLASS_F         3'h5
`define CLASS_CONTROL   3'h6

// ----------------------------------------------------------------
// measuring modes
// ----------------------------------------------------------------
`define MODE_3PH_NEUTRAL 2'h0
`define MODE_3PH_NO_NEUT 2'h1
`define MODE_SINGLE_PHASE_TWO_WIRE      2'h2

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_MHZ          200
`define TICK_US          1000
`define TICK_CYCLES      (`CLK_MHZ * `TICK_US)
`define HORN_DELAY_RESET 32'h0000_0000
`define ACK_DELAY_RESET  32'h0000_0000

// ----------------------------------------------------------------
// irq status bits
// ----------------------------------------------------------------
`define IRQ_MISMATCH    0
`define IRQ_HORN        1
`define IRQ_ACK         2

`endif

/* src/tick_divider.v */
// Purpose: common time-base tick from the system clock
// Assumes: one clock domain
// Notes:   one-cycle enable pulse
`timescale 1ns/10ps
`default_nettype none
module tick_divider #(
    parameter integer DIV = 200000
) (
    input  wire clk,
    input  wire rst,
    output reg  tick
);
    reg [31:0] cnt_q;

    // ----------------------------------------------------------------
    // divider
    // ----------------------------------------------------------------
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 32'h0000_0000;
            tick  <= 1'b0;
        end else if (cnt_q == DIV - 1) begin
            cnt_q <= 32'h0000_0000;
            tick  <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 32'h0000_0001;
            tick  <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* src/ack_qualifier.v */
// Purpose: on/off delay qualifier for the external acknowledge
// Assumes: input already synchronised, tick from common time base
// Notes:   emits one pulse per accepted true phase
`timescale 1ns/10ps
`default_nettype none
module ack_qualifier #(
    parameter integer W = 16
) (
    input  wire         clk,
    input  wire         rst,
    input  wire         tick,
    input  wire         level,
    input  wire [W-1:0] on_delay,
    input  wire [W-1:0] off_delay,
    output reg          pulse
);
    localparam [1:0] S_ARMED = 2'b01;
    localparam [1:0] S_HELD  = 2'b10;

    reg [1:0]   state_q;
    reg [W-1:0] cnt_q;

    // ----------------------------------------------------------------
    // qualifier
    // ----------------------------------------------------------------
    // off-delay applies from reset too, so a stuck input is not a pulse
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= S_HELD;
            cnt_q   <= {W{1'b0}};
            pulse   <= 1'b0;
        end else begin
            pulse <= 1'b0;
            case (state_q)
                S_ARMED: begin
                    if (!level) begin
                        cnt_q <= {W{1'b0}};
                    end else if (cnt_q >= on_delay) begin
                        pulse   <= 1'b1;
                        state_q <= S_HELD;
                        cnt_q   <= {W{1'b0}};
                    end else if (tick) begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                S_HELD: begin
                    if (level) begin
                        cnt_q <= {W{1'b0}};
                    end else if (cnt_q >= off_delay) begin
                        state_q <= S_ARMED;
                        cnt_q   <= {W{1'b0}};
                    end else if (tick) begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                default: begin
                    state_q <= S_HELD;
                    cnt_q   <= {W{1'b0}};
                end
            endcase
        end
    end
endmodule
`default_nettype wire

/* sim/rotation_alarm_chk.sv */
// Purpose: port-level checker for the rotation alarm block
// Assumes: one clock domain, async active-high reset
// Notes:   pins reach the alarm flag four sampled edges later
`timescale 1ns/10ps
`default_nettype none
module rotation_alarm_chk (
    input wire logic       CLK_SYS,
    input wire logic       RST,
    input wire logic       HREADYOUT,
    input wire logic       HRESP,
    input wire logic [1:0] MODE_A,
    input wire logic [1:0] MODE_B,
    input wire logic       ROT_A,
    input wire logic       ROT_B,
    input wire logic       VOLT_OK_A,
    input wire logic       VOLT_OK_B,
    input wire logic       SYNC_CLOSE_REQ,
    input wire logic       DEAD_BUS_CLOSE_REQ,
    input wire logic       SYNC_CLOSE_EN,
    input wire logic       DEAD_BUS_CLOSE_EN,
    input wire logic       MISMATCH_FLAG,
    input wire logic       ROTATION_MISMATCH_MESSAGE,
    input wire logic [2:0] ALARM_CLASS,
    input wire logic       HORN_FLAG,
    input wire logic       LAMP_FLASH,
    input wire logic       IRQ
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    property p_sync;
        !$past(RST) && !$past(RST, 2) |-> SYNC_CLOSE_EN == ($past(SYNC_CLOSE_REQ, 2) && !MISMATCH_FLAG);
    endproperty
    a_sync: assert property (p_sync)
        else $error("sync close enable wrong");
    property p_dead;
        !$past(RST) && !$past(RST, 2) |-> DEAD_BUS_CLOSE_EN == $past(DEAD_BUS_CLOSE_REQ, 2);
    endproperty
    a_dead: assert property (p_dead)
        else $error("dead bus close enable wrong");
    property p_msg;
        ROTATION_MISMATCH_MESSAGE == MISMATCH_FLAG;
    endproperty
    a_msg: assert property (p_msg)
        else $error("message differs from flag");
    // stimulus holds pins steady, so a fixed lookback is safe
    property p_volt;
        $rose(MISMATCH_FLAG) |-> $past(VOLT_OK_A, 4) && $past(VOLT_OK_B, 4) && $past(ROT_A, 4) != $past(ROT_B, 4);
    endproperty
    a_volt: assert property (p_volt)
        else $error("alarm without valid mismatch");
    property p_single;
        $rose(MISMATCH_FLAG) |-> !($past(MODE_A, 4) == 2'h2 && $past(MODE_B, 4) == 2'h2);
    endproperty
    a_single: assert property (p_single)
        else $error("alarm in single phase mode");
    property p_class_quiet;
        $rose(MISMATCH_FLAG) && (ALARM_CLASS == 3'h0 || ALARM_CLASS == 3'h6) |-> !$rose(HORN_FLAG);
    endproperty
    a_class_quiet: assert property (p_class_quiet)
        else $error("horn for silent class");
    property p_horn_new;
        $rose(MISMATCH_FLAG) && ALARM_CLASS >= 3'h1 && ALARM_CLASS <= 3'h5 |-> HORN_FLAG && LAMP_FLASH;
    endproperty
    a_horn_new: assert property (p_horn_new)
        else $error("new alarm without horn and flash");
    property p_horn_cause;
        $rose(HORN_FLAG) |-> LAMP_FLASH && MISMATCH_FLAG;
    endproperty
    a_horn_cause: assert property (p_horn_cause)
        else $error("horn without new alarm");
    property p_bus_okay;
        HREADYOUT && !HRESP;
    endproperty
    a_bus_okay: assert property (p_bus_okay)
        else $error("bus wait or error seen");
    c_alarm: cover property ($rose(MISMATCH_FLAG));
    c_horn_off: cover property ($fell(HORN_FLAG) && MISMATCH_FLAG);
    c_irq: cover property ($rose(IRQ));
endmodule
bind rotation_alarm rotation_alarm_chk i_chk (.*);
`default_nettype wire

/* sim/meas_front.sv */
// Purpose: measurement front end and operator inputs
// Assumes: all lines are levels changed after a rising edge
// Notes:   tasks are called from the bench
`timescale 1ns/10ps
`default_nettype none
module meas_front (
    input  wire logic       clk,
    output logic [1:0] mode_a,
    output logic [1:0] mode_b,
    output logic       rot_a,
    output logic       rot_b,
    output logic       volt_a,
    output logic       volt_b,
    output logic       lock_cond,
    output logic       ack_cond,
    output logic       button,
    output logic       dead_req,
    output logic       sync_req
);
    initial begin
        {mode_a, mode_b, rot_a, rot_b, volt_a, volt_b} = 8'h00;
        {lock_cond, ack_cond, button, dead_req, sync_req} = 5'h00;
    end
    task automatic meas(input logic [1:0] ma, mb, input logic ra, rb, va, vb);
        @(posedge clk);
        {mode_a, mode_b, rot_a, rot_b, volt_a, volt_b} <= {ma, mb, ra, rb, va, vb};
    endtask
    task automatic close(input logic s, d);
        @(posedge clk);
        {sync_req, dead_req} <= {s, d};
    endtask
    task automatic lock(input logic v);
        @(posedge clk);
        lock_cond <= v;
    endtask
    // true phase then a full false phase, so the next pulse can count
    task automatic pulse(input int hi, lo);
        @(posedge clk);
        ack_cond <= 1'b1;
        repeat (hi) @(posedge clk);
        ack_cond <= 1'b0;
        repeat (lo) @(posedge clk);
    endtask
    task automatic press;
        @(posedge clk);
        button <= 1'b1;
        repeat (3) @(posedge clk);
        button <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
endmodule
`default_nettype wire

/* sim/test_rotation_alarm.sv */
// Purpose: self-checking bench for the rotation alarm block
// Assumes: zero-wait bus slave, tick every 4 cycles
// Notes:   ack delays 2 ticks on and off
`timescale 1ns/10ps
`default_nettype none
`include "rotation_alarm_defines.vh"
module test_rotation_alarm;
    logic        CLK_SYS = 1'b0;
    logic        RST     = 1'b1;
    logic        HSEL    = 1'b0;
    logic [31:0] HADDR   = 32'h0;
    logic [1:0]  HTRANS  = 2'h0;
    logic        HWRITE  = 1'b0;
    logic [2:0]  HSIZE   = 3'h2;
    logic [31:0] HWDATA  = 32'h0;
    wire  [31:0] HRDATA;
    wire         HREADYOUT, HRESP, SYNC_CLOSE_EN, DEAD_BUS_CLOSE_EN, MISMATCH_FLAG, ROTATION_MISMATCH_MESSAGE;
    wire         HORN_FLAG, LAMP_ON, LAMP_FLASH, IRQ, ROT_A, ROT_B, VOLT_OK_A, VOLT_OK_B;
    wire         DISCRETE_INPUT_ONE, DISCRETE_INPUT_TWO, BUTTON_ACK, DEAD_BUS_CLOSE_REQ, SYNC_CLOSE_REQ;
    wire  [1:0]  MODE_A, MODE_B;
    wire  [2:0]  ALARM_CLASS;
    int          n_fail = 0;
    int          checks = 0;
    int          cycles = 0;
    logic [31:0] v;
    always #2.5 CLK_SYS = ~CLK_SYS;
    meas_front i_meas_front (.clk(CLK_SYS), .mode_a(MODE_A), .mode_b(MODE_B), .rot_a(ROT_A), .rot_b(ROT_B),
        .volt_a(VOLT_OK_A), .volt_b(VOLT_OK_B), .lock_cond(DISCRETE_INPUT_ONE), .ack_cond(DISCRETE_INPUT_TWO),
        .button(BUTTON_ACK), .dead_req(DEAD_BUS_CLOSE_REQ), .sync_req(SYNC_CLOSE_REQ));
    rotation_alarm #(.TICK_DIV(4)) i_rotation_alarm (.HREADY(HREADYOUT), .*);
    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic report_and_stop;
        $display("checks %0d failures %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge CLK_SYS);
    endtask
    task automatic wait_rdy;
        @(posedge CLK_SYS);
        while (HREADYOUT !== 1'b1) @(posedge CLK_SYS);
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge CLK_SYS);
        {HSEL, HADDR, HTRANS, HWRITE, HSIZE} <= {1'b1, 24'h0, a, 2'h2, w, 3'h2};
        wait_rdy();
        {HSEL, HTRANS, HWDATA} <= {1'b0, 2'h0, wd};
        wait_rdy();
        rd = HRDATA;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        bus(1'b0, a, 32'h0, d);
    endtask
    task automatic fault(input logic on);
        i_meas_front.meas(2'h0, 2'h0, 1'b1, ~on, 1'b1, 1'b1);
        cyc(10);
    endtask
    // a hang ends in the same closing report
    always @(posedge CLK_SYS) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            report_and_stop();
        end
    end
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        cyc(4);
        RST <= 1'b0;
        rd(`REG_CTRL, v); check(v, `CTRL_RESET);
        rd(`REG_HORN_DELAY, v); check(v, `HORN_DELAY_RESET);
        wr(8'h20, 32'hFFFF_FFFF);
        rd(8'h20, v); check(v, 32'h0);
        rd(`REG_CTRL, v); check(v, `CTRL_RESET);
        check(ALARM_CLASS, `CLASS_B);
        wr(`REG_ACK_DELAY, 32'h0002_0002);
        wr(`REG_MASK, 32'h0);
        i_meas_front.close(1'b1, 1'b1);
        fault(1'b1);
        check(MISMATCH_FLAG, 1'b1);
        check(SYNC_CLOSE_EN, 1'b0);
        check(DEAD_BUS_CLOSE_EN, 1'b1);
        check(ROTATION_MISMATCH_MESSAGE, 1'b1);
        check(LAMP_FLASH, 1'b1);
        check(IRQ, 1'b0);
        cyc(100); check(HORN_FLAG, 1'b1);
        wr(`REG_MASK, 32'h1); cyc(1); check(IRQ, 1'b1);
        rd(`REG_IRQ_STATUS, v); check(v, 32'h3);
        cyc(1); check(IRQ, 1'b0);
        fault(1'b0);
        check(MISMATCH_FLAG, 1'b0);
        check(SYNC_CLOSE_EN, 1'b1);
        i_meas_front.press(); check(HORN_FLAG, 1'b0);
        wr(`REG_HORN_DELAY, 32'h3);
        fault(1'b1); check(HORN_FLAG, 1'b1);
        cyc(20); check(HORN_FLAG, 1'b0);
        check({LAMP_FLASH, LAMP_ON}, 2'h1);
        rd(`REG_STATUS, v); check(v & 32'h1C, 32'h04);
        fault(1'b0);
        wr(`REG_HORN_DELAY, 32'h0);
        wr(`REG_CTRL, 32'h11);
        fault(1'b1);
        fault(1'b0); check(MISMATCH_FLAG, 1'b1);
        i_meas_front.pulse(3, 20); check(HORN_FLAG, 1'b1);
        i_meas_front.pulse(16, 20); check(HORN_FLAG, 1'b0);
        check(MISMATCH_FLAG, 1'b1);
        i_meas_front.pulse(16, 20); check(MISMATCH_FLAG, 1'b0);
        rd(`REG_IRQ_STATUS, v); check(v & 32'h4, 32'h4);
        wr(`REG_CTRL, 32'h17);
        i_meas_front.lock(1'b1);
        fault(1'b1); check(MISMATCH_FLAG, 1'b0);
        i_meas_front.lock(1'b0); cyc(10); check(MISMATCH_FLAG, 1'b1);
        i_meas_front.lock(1'b1);
        wr(`REG_CTRL, 32'h13); cyc(10); check(MISMATCH_FLAG, 1'b1);
        i_meas_front.lock(1'b0);
        fault(1'b0);
        wr(`REG_CTRL, 32'h12);
        fault(1'b1); check(MISMATCH_FLAG, 1'b0);
        wr(`REG_CTRL, 32'h13);
        i_meas_front.meas(2'h0, 2'h0, 1'b1, 1'b0, 1'b1, 1'b0); cyc(10); check(MISMATCH_FLAG, 1'b0);
        i_meas_front.meas(2'h2, 2'h2, 1'b1, 1'b0, 1'b1, 1'b1); cyc(10); check(MISMATCH_FLAG, 1'b0);
        i_meas_front.meas(2'h1, 2'h0, 1'b1, 1'b0, 1'b1, 1'b1); cyc(10); check(MISMATCH_FLAG, 1'b1);
        fault(1'b0);
        for (int c = 0; c < 7; c++) begin
            i_meas_front.press();
            wr(`REG_CTRL, 32'h03 | (c << 4)); cyc(2); check(ALARM_CLASS, c[2:0]);
            fault(1'b1); check(HORN_FLAG, (c >= 1 && c <= 5));
            fault(1'b0);
        end
        report_and_stop();
    end
endmodule
`default_nettype wire
